// File: uis_defs.svh
// constants for the uart interrupt and shadow block
`ifndef UIS_DEFS_SVH
`define UIS_DEFS_SVH
// register word offsets (byte address = offset)
`define UIS_OFF_DATA     8'h00
`define UIS_OFF_IER      8'h04
`define UIS_OFF_IIR_FCR  8'h08
`define UIS_OFF_LSR      8'h14
`define UIS_OFF_SFE      8'h98
`define UIS_OFF_SRT      8'h9C
`define UIS_OFF_STER     8'hA0
`define UIS_OFF_BURST_LO 8'h30
`define UIS_OFF_BURST_HI 8'h6C
// interrupt identification codes
`define UIS_ID_NONE      4'h1
`define UIS_ID_RLS       4'h6
`define UIS_ID_RDA       4'h4
`define UIS_ID_CTO       4'hC
`define UIS_ID_TX_HOLD_EMPTY      4'h2
// field positions
`define UIS_FCR_FE_BIT   0
`define UIS_IER_PTIME    7
`define UIS_LSR_TX_HOLD_EMPTY     5
// reset values
`define UIS_IER_RST      8'h00
`define UIS_FCR_RST      8'h00
// timeout length in character times
`define UIS_TO_CHARS     4
`endif

// File: uis_pkg.sv
// types shared by the uart interrupt and shadow block
package uis_pkg;
  typedef logic [7:0] uis_byte_t;
  typedef enum logic [1:0] {
    UIS_TX_EMPTY = 2'h0,
    UIS_TX_TWO   = 2'h1,
    UIS_TX_QTR   = 2'h2,
    UIS_TX_HALF  = 2'h3
  } uis_tx_thr_e;
endpackage : uis_pkg

// File: uis_src_if.sv
// interrupt source levels passed from the top to the priority encoder
`timescale 1ns/1ps
`default_nettype none
interface uis_src_if;
  logic       rls;
  logic       rda;
  logic       cto;
  logic       tx_hold_empty;
  logic [3:0] id;
  modport src (output rls, output rda, output cto, output tx_hold_empty, input id);
  modport enc (input rls, input rda, input cto, input tx_hold_empty, output id);
endinterface : uis_src_if
`default_nettype wire

// File: uis_prio.sv
// priority encoder for the interrupt identification code
`include "uis_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module uis_prio (
  uis_src_if.enc s
);
  // highest pending source only wins
  assign s.id = s.rls  ? `UIS_ID_RLS  :   // R18
                s.rda  ? `UIS_ID_RDA  :
                s.cto  ? `UIS_ID_CTO  :
                s.tx_hold_empty ? `UIS_ID_TX_HOLD_EMPTY : `UIS_ID_NONE; // R1
endmodule : uis_prio
`default_nettype wire

// File: uis_top.sv
// uart interrupt identification, threshold and shadow register logic
// Behaviour
// R1: identification low nibble reports pending source, 0001 means none
// R2: line status errors raise code 0110, highest; cleared by line status read
// R3: receive data code 0100; set on data or trigger, cleared by read/drop
// R4: timeout code 1100 in fifo mode after 4 idle char times; cleared by read
// R5: tx empty code 0010; cleared by ident read, holding write or level rise
// R6: software sets enable bit 7 to enable threshold mode
// R7: threshold mode asserts tx empty at or below programmed level
// R8: threshold from fifo control bits 5:4: empty, 2, quarter, half
// R9: in threshold mode line status bit 5 shows fifo full
// R10: fifo disable forces threshold mode inactive
// R11: outside threshold mode interrupt and bit 5 show empty holding/fifo
// R12: burst address range reads all return the receive buffer
// R13: burst address range writes all go to the holding register
// R14: alias reads or writes only the fifo enable bit
// R15: alias reads or writes only the receive trigger field
// R16: alias reads or writes only the threshold field
// R17: interrupt output high when any enabled source is active
// R18: several pending sources present only the highest priority code
`include "uis_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module uis_top
  import uis_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int LVL_W      = 5
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             clk_en_i,
  input  wire logic [7:0]       addr_i,
  input  wire uis_pkg::uis_byte_t wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output var  uis_pkg::uis_byte_t rdata_o,
  input  wire uis_pkg::uis_byte_t rx_data_i,
  input  wire logic [LVL_W-1:0] rx_level_i,
  input  wire logic [LVL_W-1:0] tx_level_i,
  input  wire logic             rx_err_i,
  input  wire logic [3:0]       rx_err_bits_i,
  input  wire logic             char_tick_i,
  input  wire logic             rx_push_i,
  input  wire logic             tx_pop_i,
  output logic                  rx_pop_o,
  output logic                  tx_push_o,
  output var  uis_pkg::uis_byte_t tx_data_o,
  output var  uis_pkg::uis_byte_t fcr_o,
  output logic                  irq_o
);
  import uis_pkg::*;

  // ***************************************
  // register decode
  // ***************************************
  logic       in_burst, hit_data, hit_ier, hit_iir, hit_lsr, hit_sfe, hit_srt, hit_ster;
  logic       rd_data, rd_iir, rd_lsr, wr_data, wr_ier, wr_fcr;
  logic       fire;
  assign fire     = clk_en_i;
  assign in_burst = (addr_i >= `UIS_OFF_BURST_LO) && (addr_i <= `UIS_OFF_BURST_HI)
                    && (addr_i[1:0] == 2'h0);
  assign hit_data = (addr_i == `UIS_OFF_DATA) || in_burst;        // R12 R13
  assign hit_ier  = addr_i == `UIS_OFF_IER;
  assign hit_iir  = addr_i == `UIS_OFF_IIR_FCR;
  assign hit_lsr  = addr_i == `UIS_OFF_LSR;
  assign hit_sfe  = addr_i == `UIS_OFF_SFE;
  assign hit_srt  = addr_i == `UIS_OFF_SRT;
  assign hit_ster = addr_i == `UIS_OFF_STER;
  assign rd_data  = fire && rd_i && hit_data;
  assign rd_iir   = fire && rd_i && hit_iir;
  assign rd_lsr   = fire && rd_i && hit_lsr;
  assign wr_data  = fire && wr_i && hit_data;
  assign wr_ier   = fire && wr_i && hit_ier;
  assign wr_fcr   = fire && wr_i && hit_iir;

  // ***************************************
  // control registers
  // ***************************************
  uis_byte_t ier_q, fcr_q, fcr_d;
  // aliases touch only their own field; the rest of fcr is kept
  always_comb begin
    fcr_d = fcr_q;
    if (wr_fcr) begin
      fcr_d = wdata_i;
    end else if (fire && wr_i && hit_sfe) begin
      fcr_d[`UIS_FCR_FE_BIT] = wdata_i[0];                       // R14
    end else if (fire && wr_i && hit_srt) begin
      fcr_d[7:6] = wdata_i[1:0];                                 // R15
    end else if (fire && wr_i && hit_ster) begin
      fcr_d[5:4] = wdata_i[1:0];                                 // R16
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ier_q <= `UIS_IER_RST;
      fcr_q <= `UIS_FCR_RST;
    end else if (fire) begin
      if (wr_ier) ier_q <= wdata_i;
      fcr_q <= fcr_d;
    end
  end

  // ***************************************
  // levels and thresholds
  // ***************************************
  localparam logic [LVL_W-1:0] LV_TWO  = LVL_W'(2);
  localparam logic [LVL_W-1:0] LV_QTR  = LVL_W'(FIFO_DEPTH / 4);
  localparam logic [LVL_W-1:0] LV_HALF = LVL_W'(FIFO_DEPTH / 2);
  localparam logic [LVL_W-1:0] LV_FULL = LVL_W'(FIFO_DEPTH);
  localparam logic [LVL_W-1:0] LV_TRQ  = LVL_W'(FIFO_DEPTH - 2);
  logic             fifo_en, ptime, tx_at_thr, tx_empty, tx_full, rx_trig;
  logic [LVL_W-1:0] thr_lvl, rx_trig_lvl;
  assign fifo_en = fcr_q[`UIS_FCR_FE_BIT];
  // fifo disable overrides the enable bit
  assign ptime   = ier_q[`UIS_IER_PTIME] && fifo_en;             // R6 R10
  always_comb begin
    unique case (uis_tx_thr_e'(fcr_q[5:4]))                      // R8
      UIS_TX_EMPTY: thr_lvl = '0;
      UIS_TX_TWO:   thr_lvl = LV_TWO;
      UIS_TX_QTR:   thr_lvl = LV_QTR;
      UIS_TX_HALF:  thr_lvl = LV_HALF;
    endcase
  end
  always_comb begin
    unique case (fcr_q[7:6])
      2'h0:    rx_trig_lvl = LVL_W'(1);
      2'h1:    rx_trig_lvl = LV_QTR;
      2'h2:    rx_trig_lvl = LV_HALF;
      2'h3:    rx_trig_lvl = LV_TRQ;
    endcase
  end
  assign tx_empty  = tx_level_i == '0;
  assign tx_full   = tx_level_i >= LV_FULL;
  assign tx_at_thr = tx_level_i <= thr_lvl;                      // R7
  assign rx_trig   = fifo_en ? (rx_level_i >= rx_trig_lvl) : (rx_level_i != '0); // R3

  // ***************************************
  // interrupt sources
  // ***************************************
  logic       rls_q, tx_hold_empty_q, tx_hold_empty_cond, tx_hold_empty_cond_q, cto_q;
  logic [2:0] char_cnt_q;
  logic [3:0] err_q;
  // threshold mode swaps the trigger from empty to at-threshold
  assign tx_hold_empty_cond = ptime ? tx_at_thr : tx_empty;               // R7 R11
  uis_src_if src ();
  assign src.rls  = rls_q && ier_q[2];                           // R2
  assign src.rda  = rx_trig && ier_q[0];                         // R3
  assign src.cto  = cto_q && ier_q[0];                           // R4
  assign src.tx_hold_empty = tx_hold_empty_q && ier_q[1];                          // R5
  uis_prio u_prio (.s(src.enc));

  // error flag: a new error beats the clearing read
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rls_q <= 1'b0;
      err_q <= 4'h0;
    end else if (fire) begin
      rls_q <= rx_err_i | (rls_q & ~rd_lsr);                     // R2
      err_q <= rx_err_bits_i | (err_q & {4{~rd_lsr}});
    end
  end

  // timeout counts idle character times while data waits
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      char_cnt_q <= 3'h0;
      cto_q      <= 1'b0;
    end else if (fire) begin
      if (!fifo_en || rx_level_i == '0 || rx_push_i || rd_data) begin
        char_cnt_q <= 3'h0;
        cto_q      <= 1'b0;                                      // R4
      end else if (char_tick_i && char_cnt_q != 3'(`UIS_TO_CHARS)) begin
        char_cnt_q <= char_cnt_q + 3'h1;
        cto_q      <= (char_cnt_q + 3'h1) == 3'(`UIS_TO_CHARS);  // R4
      end
    end
  end

  // holding-empty flag fires on the rising condition; ident read or write clears
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_hold_empty_q      <= 1'b0;
      tx_hold_empty_cond_q <= 1'b0;
    end else if (fire) begin
      tx_hold_empty_cond_q <= tx_hold_empty_cond;
      if (tx_hold_empty_cond && !tx_hold_empty_cond_q) begin
        tx_hold_empty_q <= 1'b1;                                          // R5
      end else if (!tx_hold_empty_cond || wr_data ||
                   (rd_iir && src.id == `UIS_ID_TX_HOLD_EMPTY)) begin
        tx_hold_empty_q <= 1'b0;                                          // R5
      end
    end
  end

  // ***************************************
  // read data and outputs
  // ***************************************
  uis_byte_t rd_mux;
  logic      lsr5;
  assign lsr5 = ptime ? tx_full : tx_empty;                      // R9 R11
  assign rd_mux = (rd_i && hit_data) ? rx_data_i :                // R12
                  (rd_i && hit_ier)  ? ier_q :
                  (rd_i && hit_iir)  ? {fifo_en, fifo_en, 2'h0, src.id} : // R1
                  (rd_i && hit_lsr)  ? {1'b0, tx_empty, lsr5, err_q, rx_level_i != '0} :
                  (rd_i && hit_sfe)  ? {7'h00, fcr_q[0]} :        // R14
                  (rd_i && hit_srt)  ? {6'h00, fcr_q[7:6]} :      // R15
                  (rd_i && hit_ster) ? {6'h00, fcr_q[5:4]} :      // R16
                  8'h00;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o   <= 8'h00;
      rx_pop_o  <= 1'b0;
      tx_push_o <= 1'b0;
      tx_data_o <= 8'h00;
      fcr_o     <= `UIS_FCR_RST;
      irq_o     <= 1'b0;
    end else if (fire) begin
      rdata_o   <= rd_mux;
      rx_pop_o  <= rd_data;
      tx_push_o <= wr_data;                                      // R13
      if (wr_data) tx_data_o <= wdata_i;
      fcr_o     <= fcr_d;
      irq_o     <= src.id != `UIS_ID_NONE;                       // R17
    end
  end

  // ***************************************
  // assertions
  // ***************************************
  // enabled sources seen apart from the encoder, so a broken encoder cannot hide
  logic any_src;
  assign any_src = (rls_q && ier_q[2]) || ((rx_trig || cto_q) && ier_q[0]) ||
                   (tx_hold_empty_q && ier_q[1]);
  // steps of the holding-empty flag and of the timeout count
  sequence s_tx_hold_empty_rise;
    fire && tx_hold_empty_cond && !tx_hold_empty_cond_q;
  endsequence
  sequence s_tx_hold_empty_named_rd;
    rd_iir && (src.id == `UIS_ID_TX_HOLD_EMPTY) && (tx_hold_empty_cond_q || !tx_hold_empty_cond);
  endsequence
  sequence s_cto_last;
    fire && fifo_en && (rx_level_i != '0) && !rx_push_i && !rd_data && char_tick_i &&
      (char_cnt_q == 3'(`UIS_TO_CHARS - 1));
  endsequence
  a_irq_follows_id: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R17
    clk_en_i |=> irq_o == $past(any_src))
    else $error("irq does not follow enabled sources");
  a_rls_top_prio: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R2
    src.rls |-> src.id == `UIS_ID_RLS)
    else $error("line status not highest");
  a_prio_order: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R18
    (!src.rls && src.rda) |-> src.id == `UIS_ID_RDA)
    else $error("receive data priority wrong");
  a_none_code: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R1
    !(src.rls || src.rda || src.cto || src.tx_hold_empty) |-> src.id == `UIS_ID_NONE)
    else $error("idle code wrong");
  a_rls_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R2
    (rd_lsr && !rx_err_i) |=> !rls_q)
    else $error("line status read did not clear");
  a_ptime_off: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R10
    (rd_lsr && !fifo_en && ier_q[`UIS_IER_PTIME]) |=>
      rdata_o[`UIS_LSR_TX_HOLD_EMPTY] == ($past(tx_level_i) == '0))
    else $error("threshold mode active without fifo");
  a_lsr5_full: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R9
    (rd_lsr && ptime) |=> rdata_o[`UIS_LSR_TX_HOLD_EMPTY] == ($past(tx_level_i) >= LV_FULL))
    else $error("lsr5 not full flag");
  a_lsr5_norm: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R11
    (rd_lsr && !ptime) |=> rdata_o[`UIS_LSR_TX_HOLD_EMPTY] == ($past(tx_level_i) == '0))
    else $error("lsr5 not empty flag");
  a_tx_hold_empty_set: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R5
    s_tx_hold_empty_rise |=> tx_hold_empty_q)
    else $error("holding empty flag not set");
  a_tx_hold_empty_wr_clr: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R5
    (wr_data && tx_hold_empty_cond_q && tx_hold_empty_cond) |=> !tx_hold_empty_q)
    else $error("holding write did not clear");
  a_tx_hold_empty_id_clr: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R5
    s_tx_hold_empty_named_rd |=> !tx_hold_empty_q)
    else $error("ident read did not clear");
  a_sfe_only: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R14
    (fire && wr_i && hit_sfe) |=> fcr_q[0] == $past(wdata_i[0]) &&
      fcr_q[7:1] == $past(fcr_q[7:1]))
    else $error("enable alias touched other bits");
  a_ster_only: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R16
    (fire && wr_i && hit_ster) |=> fcr_q[5:4] == $past(wdata_i[1:0]) &&
      fcr_q[7:6] == $past(fcr_q[7:6]) && fcr_q[3:0] == $past(fcr_q[3:0]))
    else $error("threshold alias wrong");
  a_srt_only: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R15
    (fire && wr_i && hit_srt) |=> fcr_q[7:6] == $past(wdata_i[1:0]) &&
      fcr_q[5:0] == $past(fcr_q[5:0]))
    else $error("trigger alias wrong");
  a_burst_rd: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R12
    (fire && rd_i && in_burst) |=> rdata_o == $past(rx_data_i) && rx_pop_o)
    else $error("burst read not receive buffer");
  a_burst_wr: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R13
    (fire && wr_i && in_burst) |=> tx_push_o && tx_data_o == $past(wdata_i))
    else $error("burst write not holding");
  a_cto_read_clr: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R4
    rd_data |=> !cto_q)
    else $error("timeout not cleared by read");
  a_cto_fourth: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R4
    s_cto_last |=> cto_q)
    else $error("timeout not raised on last idle tick");
  a_thr_mode_irq: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R7
    (fire && ptime && (tx_level_i <= thr_lvl) && !tx_hold_empty_cond_q) |=> tx_hold_empty_q)
    else $error("threshold condition missed");
endmodule : uis_top
`default_nettype wire

// File: uis_far_model.sv
// far side model: fifo fill levels, receive head byte and line events
`timescale 1ns/1ps
`default_nettype none
module uis_far_model #(
  parameter int LVL_W = 5
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rx_pop_i,
  input  wire logic             tx_push_i,
  output logic [7:0]            rx_data_o,
  output logic [LVL_W-1:0]      rx_level_o,
  output logic [LVL_W-1:0]      tx_level_o,
  output logic                  rx_err_o,
  output logic [3:0]            rx_err_bits_o,
  output logic                  char_tick_o,
  output logic                  rx_push_o,
  output logic                  tx_pop_o
);
  // ************************************************************
  // fifo bookkeeping
  // ************************************************************
  // every output has a value from time zero
  initial begin
    {rx_data_o, rx_level_o, tx_level_o} = '0;
    {rx_err_o, rx_err_bits_o, char_tick_o, rx_push_o, tx_pop_o} = '0;
  end
  // the head byte always changes on a pop from a nonempty fifo, so a stale read cannot match
  always @(posedge ref_clk_i) begin
    if (rx_pop_i && rx_level_o != '0) begin
      rx_level_o <= rx_level_o - 1'b1;
      rx_data_o  <= rx_data_o ^ 8'($urandom | 1);
    end
    if (tx_push_i && tx_level_o < LVL_W'(16)) begin
      tx_level_o <= tx_level_o + 1'b1;
    end
  end
  // move both levels at once; push and pop pulses follow the direction
  task automatic set_lvl(input logic [LVL_W-1:0] rx, input logic [LVL_W-1:0] tx);
    @(posedge ref_clk_i);
    rx_push_o  <= rx > rx_level_o;
    tx_pop_o   <= tx < tx_level_o;
    rx_level_o <= rx;
    tx_level_o <= tx;
    @(posedge ref_clk_i);
    rx_push_o <= 1'b0;
    tx_pop_o  <= 1'b0;
  endtask : set_lvl
  // character times, one pulse with a gap cycle after it
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      char_tick_o <= 1'b1;
      @(posedge ref_clk_i);
      char_tick_o <= 1'b0;
    end
  endtask : tick
  // one line error event with its cause bits
  task automatic err(input logic [3:0] bits);
    @(posedge ref_clk_i);
    rx_err_o      <= 1'b1;
    rx_err_bits_o <= bits;
    @(posedge ref_clk_i);
    rx_err_o      <= 1'b0;
    rx_err_bits_o <= 4'h0;
  endtask : err
endmodule : uis_far_model
`default_nettype wire

// File: tb_uis_top.sv
// self-checking bench for the uart interrupt and shadow block
`include "uis_defs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb_uis_top;
  import uis_pkg::*;
  // ************************************************************
  // wiring and bus tasks
  // ************************************************************
  logic            ref_clk_i, rst_i, clk_en, wr, rd, rx_pop, tx_push, irq;
  logic            rx_err, tick, rx_push, tx_pop, got_pop, got_push;
  logic [7:0]      addr, rxd, exp_rx, a, b;
  uis_byte_t       wdata, rdat, txd, fifo_control_reg, d, v, got_txd;
  logic [4:0]      rxl, txl;
  logic [3:0]      ebits;
  logic [1:0]      r, t;
  int              err_count, checked;
  uis_top u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .rx_data_i(rxd),
    .rx_level_i(rxl), .tx_level_i(txl), .rx_err_i(rx_err), .rx_err_bits_i(ebits),
    .char_tick_i(tick), .rx_push_i(rx_push), .tx_pop_i(tx_pop), .rx_pop_o(rx_pop),
    .tx_push_o(tx_push), .tx_data_o(txd), .fcr_o(fifo_control_reg), .irq_o(irq));
  uis_far_model #(.LVL_W(5)) u_far (.ref_clk_i(ref_clk_i), .rx_pop_i(rx_pop),
    .tx_push_i(tx_push), .rx_data_o(rxd), .rx_level_o(rxl), .tx_level_o(txl),
    .rx_err_o(rx_err), .rx_err_bits_o(ebits), .char_tick_o(tick), .rx_push_o(rx_push),
    .tx_pop_o(tx_pop));
  // 25 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : cyc
  // one-cycle write; push and byte are looked at in the cycle after it
  task automatic wr_reg(input logic [7:0] ad, input uis_byte_t val);
    @(posedge ref_clk_i);
    addr  <= ad;
    wdata <= val;
    wr    <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
    #1 got_push = tx_push;
    got_txd = txd;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] ad, output uis_byte_t val);
    @(posedge ref_clk_i);
    addr <= ad;
    rd   <= 1'b1;
    #1 exp_rx = rxd;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 val = rdat;
    got_pop = rx_pop;
  endtask : rd_reg
  task automatic iir(input logic [3:0] id);
    rd_reg(`UIS_OFF_IIR_FCR, d);
    `CHK(d[3:0], id)
  endtask : iir
  // tx threshold level for each field code: empty, 2, quarter, half of 16
  function automatic logic [4:0] thr_lvl(input logic [1:0] c);
    return (c == 2'h0) ? 5'h0 : (c == 2'h1) ? 5'h2 : (c == 2'h2) ? 5'h4 : 5'h8;
  endfunction : thr_lvl
  task automatic close_out();
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  // hang guard
  initial begin
    cyc(20000);
    err_count++;
    close_out();
  end
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    {rst_i, clk_en, addr, wdata, wr, rd, err_count, checked} = {2'h3, 18'h0, 64'h0};
    void'($urandom(56168));
    cyc(3);
    rst_i <= 1'b0;
    iir(4'h1);
    `CHK({irq, fifo_control_reg}, 9'h000)
    // strobes are ignored while the clock enable is low
    clk_en <= 1'b0;
    wr_reg(`UIS_OFF_SFE, 8'h01);
    clk_en <= 1'b1;
    `CHK(fifo_control_reg, 8'h00)
    // aliases touch only their own field; reset bits 2:1 are masked out
    v = (8'($urandom) & 8'hF9) | 8'h01;
    r = 2'($urandom);
    t = 2'($urandom);
    wr_reg(`UIS_OFF_IIR_FCR, v);
    wr_reg(`UIS_OFF_SRT, {6'h00, r});
    wr_reg(`UIS_OFF_STER, {6'h00, t});
    `CHK(fifo_control_reg & 8'hF9, {r, t, v[3:0]} & 8'hF9)
    rd_reg(`UIS_OFF_SRT, d);
    `CHK(d[1:0], r)
    rd_reg(`UIS_OFF_STER, d);
    `CHK(d[1:0], t)
    wr_reg(`UIS_OFF_SFE, 8'h00);
    `CHK(fifo_control_reg & 8'hF9, {r, t, v[3:1], 1'b0} & 8'hF9)
    rd_reg(`UIS_OFF_SFE, d);
    `CHK(d[0], 1'b0)
    // burst window ends first, then random words inside it
    u_far.set_lvl(5'h08, 5'h00);
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? `UIS_OFF_BURST_LO : (i == 1) ? `UIS_OFF_BURST_HI
        : `UIS_OFF_BURST_LO + 8'(4 * ($urandom % 16));
      b = `UIS_OFF_BURST_LO + 8'(4 * ($urandom % 16));
      v = 8'($urandom);
      wr_reg(a, v);
      `CHK({got_push, got_txd}, {1'b1, v})
      rd_reg(b, d);
      `CHK({got_pop, d}, {1'b1, exp_rx})
    end
    // threshold mode: each code, level just above then at the threshold
    wr_reg(`UIS_OFF_SFE, 8'h01);
    wr_reg(`UIS_OFF_IER, 8'h82);
    for (int c = 0; c < 4; c++) begin
      wr_reg(`UIS_OFF_STER, 8'(c));
      u_far.set_lvl(5'h00, thr_lvl(2'(c)) + 5'h1);
      cyc(3);
      `CHK(irq, 1'b0)
      u_far.set_lvl(5'h00, thr_lvl(2'(c)));
      cyc(3);
      `CHK(irq, 1'b1)
      iir(4'h2);
      cyc(2);
      `CHK(irq, 1'b0)
      rd_reg(`UIS_OFF_LSR, d);
      `CHK(d[5], 1'b0)
    end
    u_far.set_lvl(5'h00, 5'h10);
    cyc(3);
    rd_reg(`UIS_OFF_LSR, d);
    `CHK(d[5], 1'b1)
    wr_reg(`UIS_OFF_SFE, 8'h00);
    rd_reg(`UIS_OFF_LSR, d);
    `CHK(d[5], 1'b0)
    u_far.set_lvl(5'h00, 5'h00);
    cyc(3);
    rd_reg(`UIS_OFF_LSR, d);
    `CHK({irq, d[5]}, 2'h3)
    wr_reg(`UIS_OFF_DATA, 8'($urandom));
    cyc(3);
    `CHK(irq, 1'b0)
    // each error kind over pending receive data
    wr_reg(`UIS_OFF_IER, 8'h07);
    u_far.set_lvl(5'h01, 5'h01);
    cyc(3);
    iir(4'h4);
    `CHK(irq, 1'b1)
    for (int k = 0; k < 4; k++) begin
      u_far.err(4'h1 << k);
      cyc(3);
      iir(4'h6);
      rd_reg(`UIS_OFF_LSR, d);
      `CHK(d[4:1], 4'h1 << k)
      iir(4'h4);
    end
    wr_reg(`UIS_OFF_IER, 8'h00);
    cyc(3);
    `CHK(irq, 1'b0)
    wr_reg(`UIS_OFF_IER, 8'h07);
    rd_reg(`UIS_OFF_IER, d);
    `CHK(d, 8'h07)
    rd_reg(`UIS_OFF_DATA, d);
    `CHK(got_pop, 1'b1)
    cyc(3);
    iir(4'h1);
    // timeout needs four idle character times with data waiting
    wr_reg(`UIS_OFF_SFE, 8'h01);
    wr_reg(`UIS_OFF_SRT, 8'h03);
    wr_reg(`UIS_OFF_IER, 8'h01);
    u_far.set_lvl(5'h02, 5'h01);
    u_far.tick(3);
    cyc(2);
    iir(4'h1);
    u_far.tick(1);
    cyc(3);
    iir(4'hC);
    `CHK(d[7:6], 2'h3)
    rd_reg(`UIS_OFF_DATA, d);
    cyc(3);
    iir(4'h1);
    u_far.set_lvl(5'h0E, 5'h01);
    cyc(3);
    iir(4'h4);
    u_far.set_lvl(5'h0D, 5'h01);
    cyc(3);
    iir(4'h1);
    close_out();
  end
endmodule : tb_uis_top
`default_nettype wire
